// ### rtl/lic_pkg.sv
// Shared constants and types for the local interrupt controller glue.
package lic_pkg;

    // ------------------------------------------------------------------
    // Register space
    // ------------------------------------------------------------------
    localparam int REG_ADDR_W = 12;
    localparam int REG_DATA_W = 32;
    localparam int REG_INDEX_LSB = 4;
    localparam int REG_DEPTH = 256;
    localparam logic [REG_ADDR_W-1:0] SPURIOUS_VECTOR_OFFSET = 12'h0f0;
    localparam int SPURIOUS_ENABLE_BIT = 8;
    localparam int TEST_DISABLE_BIT = 4;
    localparam logic [REG_DATA_W-1:0] DATA_RESET = 32'h0000_0000;
    localparam logic [REG_ADDR_W-1:0] ADDR_RESET = 12'h000;

    // ------------------------------------------------------------------
    // Timing and message layout
    // ------------------------------------------------------------------
    localparam int WRITE_CYCLES = 3;
    localparam int MSG_W = 32;
    localparam int CS_W = 8;

    typedef logic [1:0] cycle_count_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WRITE = 2'b01,
        ST_HELD = 2'b11,
        ST_RESTART = 2'b10
    } wr_state_t;

    typedef struct packed {
        logic [REG_ADDR_W-1:0] addr;
        logic [REG_DATA_W-1:0] data;
    } reg_write_t;

endpackage : lic_pkg

// ### rtl/lic_reg_store.sv
// Controller register store with a registered read port.
`timescale 1ns/1ps
module lic_reg_store #(
    parameter int DATA_W = 32,
    parameter int DEPTH = 256,
    parameter int IDX_W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [IDX_W-1:0] wr_idx_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    // Read port
    input wire logic [IDX_W-1:0] rd_idx_i,
    output logic [DATA_W-1:0] rd_data_o
);

    initial begin
        if (DEPTH > (1 << IDX_W) || DEPTH < 1) begin
            $error("Depth does not fit the index width.");
        end
    end

    logic [DATA_W-1:0] mem [DEPTH];

    // The array itself has no reset, so it maps onto plain RAM.
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_idx_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= mem[rd_idx_i];
        end
    end

endmodule : lic_reg_store

// ### rtl/local_irq_virtual_wire_hold.sv
// Local interrupt controller: pass-through mode, disables, checksum retry and hold-safe register writes.
// How it works
// - In pass-through mode the request reaches the core as a level and a withdrawn request is never latched.
// - A received serial message with a bad checksum raises an error flag and is queued for resending unless the one resend slot is already taken.
// - The enable strap is caught as reset falls and a low strap keeps the controller disabled.
// - Bit 8 of the spurious vector register is the software enable, and clearing it disables by software.
// - Writing one to bit 4 of test register twelve fully disables the controller on early steppings only.
// - After a test register disable the controller stays off until the bit is zero and a warm reset follows.
// - While an internal register write runs its address is shown on the external address bus.
// - A hold arriving during a register write lets the write finish and replays it after the hold is over.
// - Hold acknowledge answers a hold request and drops after the hold request is withdrawn.
// - Every register write takes effect, including one that directly follows a replayed write.
`timescale 1ns/1ps
module local_irq_virtual_wire_hold
    import lic_pkg::*;
#(
    parameter bit EARLY_STEPPING = 1'b1,
    parameter int IDX_W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic warm_reset_i,
    // Strap
    input wire logic controller_enable_pin_i,
    // Interrupt path
    input wire logic through_local_mode_i,
    input wire logic maskable_interrupt_request_i,
    output logic core_irq_o,
    output logic controller_active_o,
    // Internal register writes from the core
    input wire logic wr_req_i,
    input wire reg_write_t wr_i,
    output logic wr_busy_o,
    output logic wr_done_o,
    input wire logic [REG_ADDR_W-1:0] rd_addr_i,
    output logic [REG_DATA_W-1:0] rd_data_o,
    // Test register twelve
    input wire logic test_wr_i,
    input wire logic [REG_DATA_W-1:0] test_wdata_i,
    output logic [REG_DATA_W-1:0] test_reg_o,
    // System bus
    input wire logic hold_i,
    input wire logic bus_backoff_i,
    output logic bus_hold_acknowledge_o,
    output logic [REG_ADDR_W-1:0] ext_addr_o,
    output logic ext_addr_valid_o,
    // Serial interrupt bus messages
    input wire logic msg_rx_valid_i,
    input wire logic [MSG_W-1:0] msg_rx_data_i,
    input wire logic [CS_W-1:0] msg_rx_checksum_i,
    input wire logic checksum_error_clear_i,
    output logic checksum_error_o,
    output logic retry_valid_o,
    output logic [MSG_W-1:0] retry_data_o,
    input wire logic retry_ready_i
);

    initial begin
        if (IDX_W != REG_ADDR_W - REG_INDEX_LSB) begin
            $error("Index width must match the register address layout.");
        end
    end

    localparam cycle_count_t LAST_COUNT = cycle_count_t'(WRITE_CYCLES - 1);
    localparam cycle_count_t COUNT_ZERO = 2'h0;
    localparam cycle_count_t COUNT_ONE = 2'h1;

    function automatic logic [IDX_W-1:0] reg_index(input logic [REG_ADDR_W-1:0] addr);
        reg_index = addr[REG_ADDR_W-1:REG_INDEX_LSB];
    endfunction : reg_index

    function automatic logic [CS_W-1:0] msg_checksum(input logic [MSG_W-1:0] data);
        logic [CS_W-1:0] sum;
        sum = '0;
        for (int i = 0; i < MSG_W / CS_W; i++) begin
            sum = sum + data[i*CS_W +: CS_W];
        end
        msg_checksum = sum;
    endfunction : msg_checksum

    // ------------------------------------------------------------------
    // Enable state
    // ------------------------------------------------------------------
    logic released_reg, released_next;
    logic pin_enabled_reg, pin_enabled_next;
    logic test_off_reg, test_off_next;
    logic [REG_DATA_W-1:0] test_reg_reg, test_reg_next;
    logic sw_enable_reg, sw_enable_next;
    logic active_reg, active_next;
    logic core_irq_reg, core_irq_next;
    logic commit;
    reg_write_t cur_reg, cur_next;

    always_comb begin
        released_next = 1'b1;
        // The strap is caught on the first edge after release, never inside the reset.
        pin_enabled_next = released_reg ? pin_enabled_reg : controller_enable_pin_i;
        test_reg_next = test_reg_reg;
        test_off_next = test_off_reg;
        if (warm_reset_i && !test_reg_reg[TEST_DISABLE_BIT]) begin
            test_off_next = 1'b0;
        end
        if (test_wr_i) begin
            test_reg_next = test_wdata_i;
            // Later steppings keep the bit reserved, so it reads back as zero there.
            test_reg_next[TEST_DISABLE_BIT] = EARLY_STEPPING & test_wdata_i[TEST_DISABLE_BIT];
            if (EARLY_STEPPING && test_wdata_i[TEST_DISABLE_BIT]) begin
                test_off_next = 1'b1;
            end
        end
        sw_enable_next = sw_enable_reg;
        if (commit && cur_reg.addr == SPURIOUS_VECTOR_OFFSET) begin
            sw_enable_next = cur_reg.data[SPURIOUS_ENABLE_BIT];
        end
        active_next = pin_enabled_next & ~test_off_next;
        if (active_reg) begin
            core_irq_next = maskable_interrupt_request_i & through_local_mode_i & sw_enable_reg;
        end else begin
            core_irq_next = maskable_interrupt_request_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            released_reg <= 1'b0;
            pin_enabled_reg <= 1'b0;
            test_off_reg <= 1'b0;
            test_reg_reg <= DATA_RESET;
            sw_enable_reg <= 1'b0;
            active_reg <= 1'b0;
            core_irq_reg <= 1'b0;
        end else begin
            released_reg <= released_next;
            pin_enabled_reg <= pin_enabled_next;
            test_off_reg <= test_off_next;
            test_reg_reg <= test_reg_next;
            sw_enable_reg <= sw_enable_next;
            active_reg <= active_next;
            core_irq_reg <= core_irq_next;
        end
    end

    // ------------------------------------------------------------------
    // Register write cycle and hold handshake
    // ------------------------------------------------------------------
    wr_state_t state_reg, state_next;
    cycle_count_t cnt_reg, cnt_next;
    logic hit_reg, hit_next;
    logic restart_reg, restart_next;
    logic hold_ack_reg, hold_ack_next;
    logic [REG_ADDR_W-1:0] ext_addr_reg, ext_addr_next;
    logic ext_valid_reg, ext_valid_next;
    logic done_reg, done_next;
    logic busy_reg, busy_next;
    logic take;
    logic bus_claim;

    assign bus_claim = hold_i | bus_backoff_i;
    assign take = (state_reg == ST_IDLE) & ~bus_claim & wr_req_i;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        cur_next = cur_reg;
        hit_next = hit_reg;
        restart_next = restart_reg;
        ext_addr_next = ext_addr_reg;
        ext_valid_next = ext_valid_reg;
        commit = 1'b0;
        done_next = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (bus_claim) begin
                    state_next = ST_HELD;
                end else if (wr_req_i) begin
                    cur_next = wr_i;
                    cnt_next = COUNT_ZERO;
                    hit_next = 1'b0;
                    ext_addr_next = wr_i.addr;
                    ext_valid_next = 1'b1;
                    state_next = ST_WRITE;
                end
            end
            ST_WRITE, ST_RESTART: begin
                hit_next = hit_reg | bus_claim;
                if (cnt_reg == LAST_COUNT) begin
                    // A hold never cuts the cycle short; it only forces a replay afterwards.
                    commit = 1'b1;
                    done_next = (state_reg == ST_WRITE);
                    ext_valid_next = 1'b0;
                    hit_next = 1'b0;
                    restart_next = hit_reg | bus_claim;
                    state_next = (hit_reg | bus_claim) ? ST_HELD : ST_IDLE;
                end else begin
                    cnt_next = cnt_reg + COUNT_ONE;
                end
            end
            ST_HELD: begin
                if (!bus_claim && !hold_ack_reg) begin
                    if (restart_reg) begin
                        cnt_next = COUNT_ZERO;
                        ext_addr_next = cur_reg.addr;
                        ext_valid_next = 1'b1;
                        state_next = ST_RESTART;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
        endcase
        hold_ack_next = (state_reg == ST_HELD) & hold_i;
        busy_next = (state_next != ST_IDLE);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            cnt_reg <= COUNT_ZERO;
            cur_reg <= '0;
            hit_reg <= 1'b0;
            restart_reg <= 1'b0;
            hold_ack_reg <= 1'b0;
            ext_addr_reg <= ADDR_RESET;
            ext_valid_reg <= 1'b0;
            done_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            cur_reg <= cur_next;
            hit_reg <= hit_next;
            restart_reg <= restart_next;
            hold_ack_reg <= hold_ack_next;
            ext_addr_reg <= ext_addr_next;
            ext_valid_reg <= ext_valid_next;
            done_reg <= done_next;
            busy_reg <= busy_next;
        end
    end

    lic_reg_store #(
        .DATA_W(REG_DATA_W),
        .DEPTH(REG_DEPTH),
        .IDX_W(IDX_W)
    ) u_store (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(commit),
        .wr_idx_i(reg_index(cur_reg.addr)),
        .wr_data_i(cur_reg.data),
        .rd_idx_i(reg_index(rd_addr_i)),
        .rd_data_o(rd_data_o)
    );

    // ------------------------------------------------------------------
    // Checksum error and resend
    // ------------------------------------------------------------------
    logic cs_err_reg, cs_err_next;
    logic retry_reg, retry_next;
    logic [MSG_W-1:0] retry_data_reg, retry_data_next;
    logic bad_msg;

    assign bad_msg = msg_rx_valid_i & (msg_checksum(msg_rx_data_i) != msg_rx_checksum_i);

    always_comb begin
        // A new error in the clearing cycle wins over the clear.
        cs_err_next = bad_msg | (cs_err_reg & ~checksum_error_clear_i);
        retry_next = retry_reg & ~retry_ready_i;
        retry_data_next = retry_data_reg;
        // One resend slot: a second bad message while one waits is not queued.
        if (bad_msg && !retry_next) begin
            retry_next = 1'b1;
            retry_data_next = msg_rx_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_err_reg <= 1'b0;
            retry_reg <= 1'b0;
            retry_data_reg <= '0;
        end else begin
            cs_err_reg <= cs_err_next;
            retry_reg <= retry_next;
            retry_data_reg <= retry_data_next;
        end
    end

    assign core_irq_o = core_irq_reg;
    assign controller_active_o = active_reg;
    assign wr_busy_o = busy_reg;
    assign wr_done_o = done_reg;
    assign test_reg_o = test_reg_reg;
    assign bus_hold_acknowledge_o = hold_ack_reg;
    assign ext_addr_o = ext_addr_reg;
    assign ext_addr_valid_o = ext_valid_reg;
    assign checksum_error_o = cs_err_reg;
    assign retry_valid_o = retry_reg;
    assign retry_data_o = retry_data_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    localparam int DONE_LAT = WRITE_CYCLES + 1;

    property p_level_drop;
        @(posedge clk_i) disable iff (rst_i)
        active_reg && !maskable_interrupt_request_i |=> !core_irq_o;
    endproperty
    a_level_drop: assert property (p_level_drop) else $error("Withdrawn request still reaches core.");

    property p_bypass;
        @(posedge clk_i) disable iff (rst_i)
        !active_reg && maskable_interrupt_request_i |=> core_irq_o;
    endproperty
    a_bypass: assert property (p_bypass) else $error("Disabled controller blocks request.");

    property p_cs_retry;
        @(posedge clk_i) disable iff (rst_i)
        bad_msg |=> checksum_error_o && retry_valid_o;
    endproperty
    a_cs_retry: assert property (p_cs_retry) else $error("Checksum error not flagged or resent.");

    property p_strap;
        @(posedge clk_i) disable iff (rst_i)
        $rose(released_reg) |-> pin_enabled_reg == $past(controller_enable_pin_i) ##1 $stable(pin_enabled_reg);
    endproperty
    a_strap: assert property (p_strap) else $error("Enable strap not caught at release.");

    property p_sw_enable;
        @(posedge clk_i) disable iff (rst_i)
        commit && cur_reg.addr == SPURIOUS_VECTOR_OFFSET |=> sw_enable_reg == $past(cur_reg.data[SPURIOUS_ENABLE_BIT]);
    endproperty
    a_sw_enable: assert property (p_sw_enable) else $error("Software enable bit not updated.");

    property p_test_off;
        @(posedge clk_i) disable iff (rst_i)
        test_wr_i && test_wdata_i[TEST_DISABLE_BIT] && EARLY_STEPPING |=> ##1 !controller_active_o;
    endproperty
    a_test_off: assert property (p_test_off) else $error("Test bit did not disable.");

    property p_stay_off;
        @(posedge clk_i) disable iff (rst_i)
        test_off_reg && !warm_reset_i |=> test_off_reg;
    endproperty
    a_stay_off: assert property (p_stay_off) else $error("Controller woke without warm reset.");

    property p_addr_shown;
        @(posedge clk_i) disable iff (rst_i)
        state_reg == ST_WRITE || state_reg == ST_RESTART |-> ext_addr_valid_o && ext_addr_o == cur_reg.addr;
    endproperty
    a_addr_shown: assert property (p_addr_shown) else $error("Write address not on external bus.");

    property p_replay;
        @(posedge clk_i) disable iff (rst_i)
        state_reg == ST_WRITE && cnt_reg == LAST_COUNT && hold_i |=> state_reg == ST_HELD && restart_reg;
    endproperty
    a_replay: assert property (p_replay) else $error("Held write not marked for replay.");

    property p_hold_ack;
        @(posedge clk_i) disable iff (rst_i)
        !hold_i |=> !bus_hold_acknowledge_o;
    endproperty
    a_hold_ack: assert property (p_hold_ack) else $error("Hold acknowledge kept after release.");

    property p_write_lands;
        @(posedge clk_i) disable iff (rst_i)
        take |-> ##[DONE_LAT:DONE_LAT] wr_done_o;
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("Accepted write never completed.");

    c_replay: cover property (@(posedge clk_i) disable iff (rst_i) state_reg == ST_RESTART);
    c_cs_error: cover property (@(posedge clk_i) disable iff (rst_i) bad_msg);
    c_test_off: cover property (@(posedge clk_i) disable iff (rst_i) test_off_reg);
    c_irq_pass: cover property (@(posedge clk_i) disable iff (rst_i) active_reg && core_irq_o);

endmodule : local_irq_virtual_wire_hold

// ### verif/chipset_model.sv
// Behavioural chipset that drives the request, hold and back-off lines of the controller.
`timescale 1ns/1ps
module chipset_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Commands from the bench
    input wire logic irq_want_i,
    input wire logic hold_want_i,
    input wire logic bus_backoff_want_i,
    // Device side
    input wire logic bus_hold_acknowledge_i,
    input wire logic wr_busy_i,
    output logic maskable_interrupt_request_o,
    output logic hold_o,
    output logic bus_backoff_o
);
    logic replay_reg;
    // No acknowledge cycles cross this boundary, so every rise is a fresh request.
    assign maskable_interrupt_request_o = irq_want_i;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            replay_reg <= 1'b0;
            hold_o <= 1'b0;
            bus_backoff_o <= 1'b0;
        end else begin
            // A hold or back-off that hits a write leaves a replay pending until the write machine idles.
            replay_reg <= wr_busy_i && (replay_reg || hold_o || bus_backoff_o);
            if (hold_want_i && !hold_o && !replay_reg) hold_o <= 1'b1;
            else if (!hold_want_i && bus_hold_acknowledge_i) hold_o <= 1'b0;
            bus_backoff_o <= bus_backoff_want_i && (bus_backoff_o || !replay_reg);
        end
    end
endmodule : chipset_model

// ### verif/tb.sv
// Self-checking bench for the local interrupt controller glue.
`timescale 1ns/1ps
module tb;
    import lic_pkg::*;
    logic clk, rst, warm, strap, mode, irq_want, hold_want, bus_backoff_want, irq, hold, bus_backoff;
    logic wr_req, wr_busy, wr_done, core_irq, active, ack, ext_valid, test_wr;
    logic msg_valid, cs_clear, cs_err, retry_valid, retry_ready;
    reg_write_t wr;
    logic [REG_ADDR_W-1:0] rd_addr, ext_addr;
    logic [REG_DATA_W-1:0] rd_data, test_wdata, test_reg;
    logic [MSG_W-1:0] msg_data, retry_data;
    logic [CS_W-1:0] msg_cs;
    logic [31:0] d, d1, d2;
    integer seed = 32'hf644;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    local_irq_virtual_wire_hold dut (.clk_i(clk), .rst_i(rst), .warm_reset_i(warm),
        .controller_enable_pin_i(strap), .through_local_mode_i(mode), .maskable_interrupt_request_i(irq),
        .core_irq_o(core_irq), .controller_active_o(active), .wr_req_i(wr_req), .wr_i(wr),
        .wr_busy_o(wr_busy), .wr_done_o(wr_done), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
        .test_wr_i(test_wr), .test_wdata_i(test_wdata), .test_reg_o(test_reg), .hold_i(hold),
        .bus_backoff_i(bus_backoff), .bus_hold_acknowledge_o(ack), .ext_addr_o(ext_addr),
        .ext_addr_valid_o(ext_valid), .msg_rx_valid_i(msg_valid), .msg_rx_data_i(msg_data),
        .msg_rx_checksum_i(msg_cs), .checksum_error_clear_i(cs_clear), .checksum_error_o(cs_err),
        .retry_valid_o(retry_valid), .retry_data_o(retry_data), .retry_ready_i(retry_ready));
    chipset_model partner (.clk_i(clk), .rst_i(rst), .irq_want_i(irq_want), .hold_want_i(hold_want),
        .bus_backoff_want_i(bus_backoff_want), .bus_hold_acknowledge_i(ack), .wr_busy_i(wr_busy),
        .maskable_interrupt_request_o(irq), .hold_o(hold), .bus_backoff_o(bus_backoff));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------
    task conclude;
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    function automatic logic [CS_W-1:0] cs_of(input logic [31:0] v);
        return v[7:0] + v[15:8] + v[23:16] + v[31:24];
    endfunction : cs_of

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            conclude();
        end
    end

    // The request is sampled once per edge, so the core line is the previous sample, gated by the mode and software enable only while active.
    task automatic irq_run(input int n, input logic act, input logic sw);
        logic r, m, pr, pm;
        pr = 1'b0;
        pm = 1'b0;
        for (int i = 0; i < n; i++) begin
            {r, m} = 2'($random(seed));
            @(posedge clk);
            irq_want <= r;
            mode <= m;
            @(negedge clk);
            if (i > 0) check("core_irq_o", core_irq, act ? (pr & pm & sw) : pr);
            pr = r;
            pm = m;
        end
    endtask : irq_run

    // Mode 0 plain write, 1 hold during the write, 2 back-off during the write.
    task automatic do_write(input logic [11:0] a, input logic [31:0] v, input int md, input int n_exp);
        int n_valid, n_done, n_ack, t;
        logic seen;
        n_valid = 0;
        n_done = 0;
        n_ack = 0;
        t = 0;
        seen = 1'b0;
        @(posedge clk);
        wr_req <= 1'b1;
        wr <= '{addr: a, data: v};
        hold_want <= (md == 1);
        bus_backoff_want <= (md == 2);
        repeat (60) begin
            @(negedge clk);
            if (ext_valid === 1'b1) n_valid++;
            if (ext_valid === 1'b1) check("ext_addr_o", 32'(ext_addr), 32'(a));
            if (wr_done === 1'b1) n_done++;
            if (ack === 1'b1) n_ack++;
            if (seen && wr_busy !== 1'b1) break;
            if (wr_busy === 1'b1) seen = 1'b1;
            t++;
            @(posedge clk);
            wr_req <= !seen;
            hold_want <= (md == 1) && (n_ack < 3);
            bus_backoff_want <= (md == 2) && (t < 5);
        end
        check("valid_cycles", n_valid, n_exp);
        check("done_pulses", n_done, 1);
        check("ack_seen", n_ack > 0, md == 1);
        check("ack_end", ack, 0);
    endtask : do_write

    task automatic read_check(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        rd_addr <= a;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("rd_data_o", rd_data, v);
    endtask : read_check

    task automatic test_write(input logic [31:0] v);
        @(posedge clk);
        test_wr <= 1'b1;
        test_wdata <= v;
        @(posedge clk);
        test_wr <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : test_write

    task automatic warm_pulse;
        @(posedge clk);
        warm <= 1'b1;
        @(posedge clk);
        warm <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : warm_pulse

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst, strap} = 2'b11;
        {warm, mode, irq_want, hold_want, bus_backoff_want, wr_req, test_wr, msg_valid, cs_clear, retry_ready} = '0;
        wr = '{addr: ADDR_RESET, data: DATA_RESET};
        {rd_addr, test_wdata, msg_data, msg_cs} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("controller_active_o", active, 1);
        irq_run(20, 1'b1, 1'b0);
        do_write(SPURIOUS_VECTOR_OFFSET, 32'h0000_0100, 0, 3);
        irq_run(30, 1'b1, 1'b1);
        d1 = $random(seed);
        d2 = $random(seed);
        do_write(12'h080, d1, 1, 6);
        do_write(12'h090, d2, 0, 3);
        do_write(12'h0a0, ~d2, 2, 6);
        read_check(12'h080, d1);
        read_check(12'h090, d2);
        read_check(12'h0a0, ~d2);
        do_write(SPURIOUS_VECTOR_OFFSET, 32'h0000_00ff, 0, 3);
        irq_run(20, 1'b1, 1'b0);
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            @(posedge clk);
            // The last bad message meets a clear in the same cycle, and the error must still stand.
            {msg_valid, cs_clear} <= {1'b1, i == 5};
            msg_data <= d;
            msg_cs <= cs_of(d) + CS_W'(i % 2);
            @(posedge clk);
            {msg_valid, cs_clear} <= 2'b00;
            @(negedge clk);
            check("checksum_error_o", cs_err, i % 2);
            check("retry_valid_o", retry_valid, i % 2);
            if (i % 2) check("retry_data_o", retry_data, d);
            @(posedge clk);
            {retry_ready, cs_clear} <= 2'b11;
            @(posedge clk);
            {retry_ready, cs_clear} <= 2'b00;
            @(negedge clk);
            check("retry_valid_o", retry_valid, 0);
        end
        test_write(32'h0000_0010);
        check("controller_active_o", active, 0);
        check("test_reg_o", test_reg, 32'h0000_0010);
        irq_run(20, 1'b0, 1'b0);
        // A warm reset while the disable bit is still set must not wake the controller.
        warm_pulse();
        check("controller_active_o", active, 0);
        test_write(32'h0000_0000);
        check("controller_active_o", active, 0);
        warm_pulse();
        check("controller_active_o", active, 1);
        // A second reset with the strap low must leave the controller out of the way.
        @(posedge clk);
        rst <= 1'b1;
        strap <= 1'b0;
        @(negedge clk);
        check("reset_outputs", {core_irq, active, wr_busy, ack, cs_err}, 0);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        strap <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("controller_active_o", active, 0);
        irq_run(20, 1'b0, 1'b0);
        conclude();
    end
endmodule : tb
